/* shared/amp_irq_consts.svh */
// Register offsets, field positions, reset values and limits of the protection status block.
// Included by the package user files; holds definitions only.
`ifndef AMP_IRQ_CONSTS_SVH
`define AMP_IRQ_CONSTS_SVH

`define REG_THERMAL_STATUS 8'h01
`define REG_FAULT_STATUS 8'h02
`define REG_THERMAL_EDGES 8'h03
`define REG_FAULT_EDGES 8'h04
`define REG_THERMAL_LATCH 8'h05
`define REG_SUPPLY_CODE 8'h06
`define REG_TEMP_CODE 8'h07

`define REG_RESET_VALUE 8'h00

// Thermal status positions
`define BIT_FOLDBACK 5
`define BIT_WARNING 3
`define BIT_SHUTDOWN 1

`define FAULT_WIDTH 7
`define THERMAL_EVENTS 3

// Foldback attenuation in half-dB steps, cap is 12 dB
`define FOLDBACK_MAX_HALF_DB 5'h18

// Defaults, one degree per temperature code step
`define DEFAULT_DEV_ADDR 7'h31
`define DEFAULT_WARN_LIMIT 8'h82
`define DEFAULT_SHUTDOWN_LIMIT 8'h96
`define DEFAULT_SHUTDOWN_HYST 8'h14

`endif

/* shared/amp_irq_pkg.sv */
// Types shared by the protection status block.
// Assumes nothing of its surroundings.
package amp_irq_pkg;

	typedef enum logic [3:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ACK_ADDR,
		BUS_POINTER,
		BUS_ACK_POINTER,
		BUS_WDATA,
		BUS_ACK_WDATA,
		BUS_RDATA,
		BUS_ACK_RDATA,
		BUS_WAIT
	} bus_state_type;

endpackage

/* logic/amp_protection_status_irq.sv */
// Protection status, event latches and interrupt pin of a mono speaker amplifier,
// with a two-wire control slave giving access to the registers.
// Assumes SCL, SDA, the reset pin and fault inputs come from outside the clock domain;
// temperature and supply codes and the host settings are same-clock logic.
//
// Behaviour
// R1: The interrupt pin is pulled low when an enabled flag bit becomes set.
// R2: While the reset pin is low the block is held in low-power reset and all registers reload.
// R3: Above the threshold the gain is reduced by a chosen dB per degree, at most 12 dB.
// R4: Above the maximum die temperature the amplifier is shut down.
// R5: Foldback and near-maximum temperature are each reported to the host as events.
// R6: Register 0x01 shows foldback in bit 5, warning in bit 3, shutdown in bit 1, else zero.
// R7: Register 0x02 shows the seven fault sources in bits 6 down to 0.
// R8: Register 0x03 shows end and begin state of each thermal event in bit pairs 5:4, 3:2, 1:0.
// R9: Register 0x04 holds a state bit per fault source at the fault status positions.
// R10: Register 0x05 holds sticky begin and end flags with the layout of register 0x03.
// R11: The digitized supply voltage is readable over the control bus.
// R12: The temperature code is readable; the host trusts it only above +100 degrees.
// R13: Shutdown follows a host command or the hardware reset pin.
// R14: A flag stays set until the host clears it, and the pin releases when none enabled remains.
// R15: Unused bits read as zero and writes to them are ignored.
`timescale 1ns/1ps
`include "amp_irq_consts.svh"

module amp_protection_status_irq #(
	parameter logic [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR,
	parameter logic [7:0] WARN_LIMIT = `DEFAULT_WARN_LIMIT,
	parameter logic [7:0] SHUTDOWN_LIMIT = `DEFAULT_SHUTDOWN_LIMIT,
	parameter logic [7:0] SHUTDOWN_HYST = `DEFAULT_SHUTDOWN_HYST
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic RESET_N,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	output logic IRQ_N_OUT,
	output logic IRQ_N_OE,
	input wire logic [6:0] FAULT_IN,
	input wire logic [7:0] TEMP_CODE,
	input wire logic [7:0] SUPPLY_CODE,
	input wire logic [7:0] FOLDBACK_THRESHOLD,
	input wire logic [1:0] FOLDBACK_SLOPE,
	input wire logic [5:0] IRQ_ENABLE,
	input wire logic SHUTDOWN_CMD,
	output logic [4:0] GAIN_REDUCTION,
	output logic AMP_SHUTDOWN,
	output logic LOW_POWER_RESET
);

	// Synchronisers: first stage feeds only the second
	logic rst_pin_s1_r, rst_pin_s2_r;
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;
	logic [6:0] fault_s1_r, fault_s2_r;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rst_pin_s1_r <= 1'b0;
			rst_pin_s2_r <= 1'b0;
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
			fault_s1_r <= 7'h00;
			fault_s2_r <= 7'h00;
		end else begin
			rst_pin_s1_r <= RESET_N;
			rst_pin_s2_r <= rst_pin_s1_r;
			scl_s1_r <= SCL_IN;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= SDA_IN;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
			fault_s1_r <= FAULT_IN;
			fault_s2_r <= fault_s1_r;
		end
	end

	wire pin_reset = ~rst_pin_s2_r; // R2
	wire scl_rise = scl_s2_r & ~scl_s3_r;
	wire scl_fall = ~scl_s2_r & scl_s3_r;
	wire bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	wire bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

	// Thermal detection
	logic heat_shutdown_active_r;
	wire foldback_active = TEMP_CODE > FOLDBACK_THRESHOLD; // R3
	wire heat_warning_active = TEMP_CODE >= WARN_LIMIT; // R5
	wire shutdown_trip = TEMP_CODE > SHUTDOWN_LIMIT; // R4
	// Hysteresis keeps the stage off until the die has really cooled
	wire shutdown_clear = TEMP_CODE < (SHUTDOWN_LIMIT - SHUTDOWN_HYST);
	wire shutdown_nxt = shutdown_trip | (heat_shutdown_active_r & ~shutdown_clear);

	// Slope codes 0..3 give 0.5, 1, 2, 2 dB per degree, in half-dB units
	wire [7:0] over_temp = TEMP_CODE - FOLDBACK_THRESHOLD;
	wire [1:0] slope_shift = (FOLDBACK_SLOPE == 2'h3) ? 2'h2 : FOLDBACK_SLOPE;
	wire [10:0] atten_raw = {3'h0, over_temp} << slope_shift;
	wire [4:0] atten_nxt = ~foldback_active ? 5'h00 :
		(atten_raw >= {6'h00, `FOLDBACK_MAX_HALF_DB}) ? `FOLDBACK_MAX_HALF_DB :
		atten_raw[4:0]; // R3

	// Thermal events ordered foldback, warning, shutdown
	wire [2:0] thermal_now = {foldback_active, heat_warning_active, heat_shutdown_active_r};
	logic [2:0] thermal_d_r;
	logic [2:0] begin_state_r, end_state_r;
	logic [2:0] begin_latch_r, end_latch_r;
	logic [6:0] fault_state_r;
	logic [6:0] fault_d_r;
	wire [2:0] thermal_rise = thermal_now & ~thermal_d_r;
	wire [2:0] thermal_fall = ~thermal_now & thermal_d_r;
	wire [6:0] fault_rise = fault_s2_r & ~fault_d_r;

	// Bus control registers
	amp_irq_pkg::bus_state_type state_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] pointer_r;
	logic read_mode_r;
	logic sda_oe_r;
	logic [7:0] tx_r;

	function automatic logic [7:0] pair_layout(input logic [2:0] ends, input logic [2:0] begins);
		pair_layout = {2'h0, ends[2], begins[2], ends[1], begins[1], ends[0], begins[0]};
	endfunction

	wire [7:0] thermal_status = {2'h0, thermal_d_r[2], 1'b0, thermal_d_r[1], 1'b0,
		thermal_d_r[0], 1'b0}; // R6
	wire [7:0] rd_data =
		(pointer_r == `REG_THERMAL_STATUS) ? thermal_status :
		(pointer_r == `REG_FAULT_STATUS) ? {1'b0, fault_d_r} : // R7
		(pointer_r == `REG_THERMAL_EDGES) ? pair_layout(end_state_r, begin_state_r) : // R8
		(pointer_r == `REG_FAULT_EDGES) ? {1'b0, fault_state_r} : // R9
		(pointer_r == `REG_THERMAL_LATCH) ? pair_layout(end_latch_r, begin_latch_r) : // R10
		(pointer_r == `REG_SUPPLY_CODE) ? SUPPLY_CODE : // R11
		(pointer_r == `REG_TEMP_CODE) ? TEMP_CODE : // R12
		`REG_RESET_VALUE; // R15

	// Byte boundaries of the bus
	wire byte_done = scl_fall & (bit_cnt_r == 4'h8);
	wire addr_match = shift_r[7:1] == DEV_ADDR;
	wire write_commit = (state_r == amp_irq_pkg::BUS_WDATA) & byte_done;
	wire latch_write = write_commit & (pointer_r == `REG_THERMAL_LATCH);
	// Only flag positions are writable; a one clears the flag
	wire [2:0] clear_begin = latch_write ? {shift_r[4], shift_r[2], shift_r[0]} : 3'h0; // R15
	wire [2:0] clear_end = latch_write ? {shift_r[5], shift_r[3], shift_r[1]} : 3'h0;
	wire load_read = scl_fall & ((state_r == amp_irq_pkg::BUS_ACK_ADDR & read_mode_r) |
		(state_r == amp_irq_pkg::BUS_ACK_RDATA));
	wire fault_state_read = load_read & (pointer_r == `REG_FAULT_EDGES);
	// Flag word in register layout, so the enable mask lines up bit for bit
	wire [7:0] latch_word = pair_layout(end_latch_r, begin_latch_r);

	// Event state, latches and outputs
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			thermal_d_r <= 3'h0;
			heat_shutdown_active_r <= 1'b0;
			begin_state_r <= 3'h0;
			end_state_r <= 3'h0;
			begin_latch_r <= 3'h0;
			end_latch_r <= 3'h0;
			fault_d_r <= 7'h00;
			fault_state_r <= 7'h00;
			GAIN_REDUCTION <= 5'h00;
			AMP_SHUTDOWN <= 1'b1;
			LOW_POWER_RESET <= 1'b1;
			IRQ_N_OE <= 1'b0;
			IRQ_N_OUT <= 1'b0;
		end else if (pin_reset) begin
			thermal_d_r <= 3'h0; // R2
			heat_shutdown_active_r <= 1'b0;
			begin_state_r <= 3'h0;
			end_state_r <= 3'h0;
			begin_latch_r <= 3'h0;
			end_latch_r <= 3'h0;
			fault_d_r <= 7'h00;
			fault_state_r <= 7'h00;
			GAIN_REDUCTION <= 5'h00;
			AMP_SHUTDOWN <= 1'b1; // R13
			LOW_POWER_RESET <= 1'b1;
			IRQ_N_OE <= 1'b0;
			IRQ_N_OUT <= 1'b0;
		end else begin
			heat_shutdown_active_r <= shutdown_nxt; // R4
			thermal_d_r <= thermal_now;
			begin_state_r <= (begin_state_r & ~thermal_fall) | thermal_rise; // R8
			end_state_r <= (end_state_r & ~thermal_rise) | thermal_fall;
			// A new event in the clearing cycle still wins
			begin_latch_r <= (begin_latch_r & ~clear_begin) | thermal_rise; // R14
			end_latch_r <= (end_latch_r & ~clear_end) | thermal_fall; // R10
			fault_d_r <= fault_s2_r; // R7
			fault_state_r <= (fault_state_r & ~(fault_state_read ? 7'h7f : 7'h00)) |
				fault_rise; // R9
			GAIN_REDUCTION <= atten_nxt; // R3
			AMP_SHUTDOWN <= SHUTDOWN_CMD | shutdown_nxt; // R13
			LOW_POWER_RESET <= 1'b0;
			IRQ_N_OE <= |(latch_word[5:0] & IRQ_ENABLE); // R1
			IRQ_N_OUT <= 1'b0;
		end
	end

	// Control bus slave: a write sets the pointer then steps it per data byte, a read streams from it
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_r <= amp_irq_pkg::BUS_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			pointer_r <= 8'h00;
			read_mode_r <= 1'b0;
			sda_oe_r <= 1'b0;
			tx_r <= 8'h00;
		end else if (pin_reset | bus_stop) begin
			state_r <= amp_irq_pkg::BUS_IDLE;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
			if (pin_reset) begin
				pointer_r <= 8'h00;
			end
		end else if (bus_start) begin
			state_r <= amp_irq_pkg::BUS_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
			amp_irq_pkg::BUS_ADDR, amp_irq_pkg::BUS_POINTER, amp_irq_pkg::BUS_WDATA: begin
				if (scl_rise) begin
					shift_r <= {shift_r[6:0], sda_s2_r};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (byte_done) begin
					bit_cnt_r <= 4'h0;
					sda_oe_r <= 1'b1;
					if (state_r == amp_irq_pkg::BUS_ADDR) begin
						read_mode_r <= shift_r[0];
						state_r <= addr_match ? amp_irq_pkg::BUS_ACK_ADDR : amp_irq_pkg::BUS_WAIT;
						sda_oe_r <= addr_match;
					end else if (state_r == amp_irq_pkg::BUS_POINTER) begin
						pointer_r <= shift_r;
						state_r <= amp_irq_pkg::BUS_ACK_POINTER;
					end else begin
						pointer_r <= pointer_r + 8'h01;
						state_r <= amp_irq_pkg::BUS_ACK_WDATA;
					end
				end
			end
			amp_irq_pkg::BUS_ACK_ADDR, amp_irq_pkg::BUS_ACK_POINTER,
			amp_irq_pkg::BUS_ACK_WDATA: begin
				if (scl_fall) begin
					if (load_read) begin
						tx_r <= {rd_data[6:0], 1'b0};
						sda_oe_r <= ~rd_data[7];
						pointer_r <= pointer_r + 8'h01;
						state_r <= amp_irq_pkg::BUS_RDATA;
					end else begin
						sda_oe_r <= 1'b0;
						state_r <= (state_r == amp_irq_pkg::BUS_ACK_ADDR) ?
							amp_irq_pkg::BUS_POINTER : amp_irq_pkg::BUS_WDATA;
					end
				end
			end
			amp_irq_pkg::BUS_RDATA: begin
				if (scl_rise) begin
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (scl_fall) begin
					if (bit_cnt_r == 4'h8) begin
						bit_cnt_r <= 4'h0;
						sda_oe_r <= 1'b0;
						state_r <= amp_irq_pkg::BUS_ACK_RDATA;
					end else begin
						sda_oe_r <= ~tx_r[7];
						tx_r <= {tx_r[6:0], 1'b0};
					end
				end
			end
			amp_irq_pkg::BUS_ACK_RDATA: begin
				// A not-acknowledge ends the read until the next start
				if (scl_rise & sda_s2_r) begin
					state_r <= amp_irq_pkg::BUS_WAIT;
				end else if (load_read) begin
					tx_r <= {rd_data[6:0], 1'b0};
					sda_oe_r <= ~rd_data[7];
					pointer_r <= pointer_r + 8'h01;
					state_r <= amp_irq_pkg::BUS_RDATA;
				end
			end
			amp_irq_pkg::BUS_WAIT: begin
				sda_oe_r <= 1'b0;
			end
			default: begin
				sda_oe_r <= 1'b0;
			end
			endcase
		end
	end

	logic sda_zero_r;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sda_zero_r <= 1'b0;
		end else begin
			sda_zero_r <= 1'b0;
		end
	end

	assign SDA_OE = sda_oe_r;
	assign SDA_OUT = sda_zero_r;

endmodule

/* testbench/amp_irq_props.sv */
// Checker of the protection status block pins.
// Assumes one clock domain; bound to the block's top module by the bench.
`timescale 1ns/1ps
module amp_irq_props #(
	parameter logic [7:0] SHUTDOWN_LIMIT = 8'h96
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic RESET_N,
	input wire logic SHUTDOWN_CMD,
	input wire logic [7:0] TEMP_CODE,
	input wire logic [5:0] IRQ_ENABLE,
	input wire logic SDA_OUT,
	input wire logic IRQ_N_OUT,
	input wire logic IRQ_N_OE,
	input wire logic [4:0] GAIN_REDUCTION,
	input wire logic AMP_SHUTDOWN,
	input wire logic LOW_POWER_RESET
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	a_gain_capped: assert property (GAIN_REDUCTION <= 5'h18) else $error("gain cap");
	a_sda_open_drain: assert property (SDA_OUT == 1'b0) else $error("sda high");
	a_irq_open_drain: assert property (IRQ_N_OUT == 1'b0) else $error("irq high");
	a_mask_quiets_irq: assert property
		(IRQ_ENABLE == 6'h00 |=> !IRQ_N_OE) else $error("masked irq");
	a_pin_reset_holds: assert property
		((!RESET_N) [*4] |-> LOW_POWER_RESET && AMP_SHUTDOWN) else $error("pin reset");
	a_pin_reset_ends: assert property
		(RESET_N [*4] |-> !LOW_POWER_RESET) else $error("reset stuck");
	a_reset_quiets_irq: assert property
		(LOW_POWER_RESET [*2] |-> !IRQ_N_OE) else $error("irq in reset");
	a_cmd_shuts_down: assert property
		(SHUTDOWN_CMD [*2] |-> ##[0:3] AMP_SHUTDOWN) else $error("no cmd stop");
	a_hot_shuts_down: assert property
		((TEMP_CODE > SHUTDOWN_LIMIT) [*2] |-> ##[0:3] AMP_SHUTDOWN) else $error("no heat stop");
endmodule

/* testbench/amp_host_model.sv */
// Host on the two-wire control bus, driving SCL and pulling SDA low.
// Assumes a pull-up on SDA resolved by the bench; moves on falling clock edges.
`timescale 1ns/1ps
module amp_host_model #(
	parameter logic [6:0] DEV = 7'h31
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	output logic rvalid,
	output logic [7:0] rdata
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rvalid = 1'b0;
		rdata = 8'h00;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Data moves a few clocks after SCL falls, so the synced pins never see a false start
	task automatic bitx(input logic b, output logic r);
		hold(3);
		sda_low = !b;
		hold(10);
		scl = 1'b1;
		hold(5);
		r = sda;
		hold(5);
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(last, a);
	endtask
	task automatic start;
		hold(3);
		sda_low = 1'b0;
		hold(10);
		scl = 1'b1;
		hold(10);
		sda_low = 1'b1;
		hold(10);
		scl = 1'b0;
	endtask
	task automatic stop;
		hold(3);
		sda_low = 1'b1;
		hold(10);
		scl = 1'b1;
		hold(10);
		sda_low = 1'b0;
		hold(10);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		start;
		xfer({DEV, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		xfer(d, 1'b1, q);
		stop;
	endtask
	task automatic rd(input logic [7:0] p);
		logic [7:0] q;
		start;
		xfer({DEV, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		start;
		xfer({DEV, 1'b1}, 1'b1, q);
		xfer(8'hff, 1'b1, q);
		stop;
		rdata = q;
		rvalid = 1'b1;
		@(negedge clk);
		rvalid = 1'b0;
	endtask
endmodule

/* testbench/amp_protection_status_irq_bench.sv */
// Self-checking bench of the protection status block with a bus host model.
// Assumes the block's default address and thermal limits.
`timescale 1ns/1ps
module amp_protection_status_irq_bench;
	logic clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1, sd_cmd = 1'b0;
	logic [6:0] fault = 7'h00;
	logic [7:0] temp = 8'h20, supply = 8'h00, thr = 8'h64;
	logic [1:0] slope = 2'h1;
	logic [5:0] ien = 6'h00;
	logic scl, sda_low, sda_oe, sda_out, irq_oe, irq_out, amp_sd, lpr, rvalid;
	logic [7:0] rdata;
	logic [4:0] gain;
	logic [7:0] exp_q[$];
	int fails = 0, n_tests = 0, cyc = 0;
	wire sda = !(sda_oe || sda_low);
	initial forever #5 clk = !clk;
	amp_protection_status_irq uut (.CLK(clk), .SYS_RST(sys_rst), .RESET_N(reset_n),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ_N_OUT(irq_out),
		.IRQ_N_OE(irq_oe), .FAULT_IN(fault), .TEMP_CODE(temp), .SUPPLY_CODE(supply),
		.FOLDBACK_THRESHOLD(thr), .FOLDBACK_SLOPE(slope), .IRQ_ENABLE(ien),
		.SHUTDOWN_CMD(sd_cmd), .GAIN_REDUCTION(gain), .AMP_SHUTDOWN(amp_sd),
		.LOW_POWER_RESET(lpr));
	amp_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
		.rvalid(rvalid), .rdata(rdata));
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(p);
	endtask
	always @(posedge clk) if (rvalid) check(rdata, exp_q.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		void'($urandom(32'hd2caf4af));
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge clk);
		for (int a = 1; a < 6; a++) rd(8'(a), 8'h00);
		$display("test reset values done");
		ien = 6'h3f;
		temp = 8'h8c;
		rd(8'h01, 8'h28);
		rd(8'h03, 8'h14);
		rd(8'h05, 8'h14);
		check(8'(irq_oe), 8'h01);
		check(8'(gain), 8'h18);
		host.wr(8'h01, 8'hff);
		host.wr(8'h05, 8'hd4);
		rd(8'h01, 8'h28);
		rd(8'h05, 8'h00);
		check(8'(irq_oe), 8'h00);
		$display("test foldback and clear done");
		fault = 7'($urandom) | 7'h01;
		supply = 8'($urandom);
		rd(8'h02, 8'(fault));
		rd(8'h04, 8'(fault));
		rd(8'h04, 8'h00);
		rd(8'h06, supply);
		rd(8'h07, temp);
		$display("test faults and codes done");
		ien = 6'h00;
		temp = 8'ha0;
		rd(8'h01, 8'h2a);
		check(8'(amp_sd), 8'h01);
		temp = 8'h50;
		rd(8'h01, 8'h00);
		rd(8'h03, 8'h2a);
		rd(8'h05, 8'h2b);
		check(8'(irq_oe), 8'h00);
		check(8'(amp_sd), 8'h00);
		check(8'(gain), 8'h00);
		ien = 6'h01;
		repeat (3) @(negedge clk);
		check(8'(irq_oe), 8'h01);
		$display("test shutdown events done");
		sd_cmd = 1'b1;
		repeat (4) @(negedge clk);
		check(8'(amp_sd), 8'h01);
		sd_cmd = 1'b0;
		reset_n = 1'b0;
		repeat (5) @(negedge clk);
		check(8'(lpr), 8'h01);
		check(8'(irq_oe), 8'h00);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		check(8'(lpr), 8'h00);
		rd(8'h05, 8'h00);
		$display("test pin reset done");
		temp = 8'h67;
		slope = 2'h0;
		repeat (3) @(negedge clk);
		check(8'(gain), 8'h03);
		thr = 8'h66;
		slope = 2'h3;
		repeat (3) @(negedge clk);
		check(8'(gain), 8'h04);
		$display("test foldback slopes done");
		test_done;
	end
endmodule
bind amp_protection_status_irq amp_irq_props #(.SHUTDOWN_LIMIT(SHUTDOWN_LIMIT)) chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .RESET_N(RESET_N), .SHUTDOWN_CMD(SHUTDOWN_CMD),
	.TEMP_CODE(TEMP_CODE), .IRQ_ENABLE(IRQ_ENABLE), .SDA_OUT(SDA_OUT), .IRQ_N_OUT(IRQ_N_OUT),
	.IRQ_N_OE(IRQ_N_OE), .GAIN_REDUCTION(GAIN_REDUCTION), .AMP_SHUTDOWN(AMP_SHUTDOWN),
	.LOW_POWER_RESET(LOW_POWER_RESET));
